//--- shared/bridge_cfg_pkg.sv
// Purpose: Shared constants for the control channel I2C bridge configuration block
// Assumes: clk_sys at 40 MHz; register index times four gives the AHB byte address
// Notes: All registers reset to zero
package bridge_cfg_pkg;
  localparam int CLK_PERIOD_NS = 25;
  // Register indices, byte address is index * 4
  localparam logic [7:0] IDX_CTL2 = 8'h06;
  localparam logic [7:0] IDX_PARTNER = 8'h07;
  localparam logic [7:0] IDX_FAR0 = 8'h08;
  localparam logic [7:0] IDX_ALIAS0 = 8'h10;
  localparam logic [7:0] IDX_STAT = 8'h11;
  localparam logic [7:0] IDX_NONE = 8'hFF;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 9;
  localparam int HTRANS_ACT = 1;
  // Control two fields
  localparam int B_SEQ_ERR = 7;
  localparam int B_SEQ_CLR = 6;
  localparam int B_DLY_LO = 3;
  localparam int B_DLY_HI = 4;
  localparam int B_WR_BLOCK = 2;
  localparam int B_FAST = 1;
  localparam int B_WD_OFF = 0;
  // Address registers: address in 7-1, partner register hold in 0
  localparam int B_ADDR_LO = 1;
  localparam int B_ADDR_HI = 7;
  localparam int B_HOLD = 0;
  // Status fields
  localparam int B_ST_FREE = 0;
  localparam int B_ST_RECOV = 1;
  localparam int B_ST_LOCK = 2;
  localparam logic [6:0] ADDR_NONE = 7'h00;
  // SDA output delay, least times round up
  localparam int SDA_BASE_NS = 250;
  localparam int SDA_STEP_NS = 50;
  localparam int SDA_BASE_CYC = (SDA_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SDA_STEP_CYC = (SDA_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SDA_TAP0 = SDA_BASE_CYC - 2;
  localparam int SDA_SR_W = SDA_TAP0 + 3 * SDA_STEP_CYC + 1;
  // Bus watchdog periods, longest times round down
  localparam int WD_FAST_NS = 50000;
  localparam int WD_FAST_CYC = WD_FAST_NS / CLK_PERIOD_NS;
  localparam int WD_SLOW_NS = 1000000000;
  localparam int WD_SLOW_CYC = WD_SLOW_NS / CLK_PERIOD_NS;
  localparam int WD_CNT_W = 26;
  // Bus recovery clocking
  localparam int RECOV_HALF_NS = 5000;
  localparam int RECOV_HALF_CYC = (RECOV_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_PULSES = 9;
endpackage : bridge_cfg_pkg

//--- hw/bridge_cfg.sv
// Purpose: Configuration, status, watchdog and address remap for the I2C bridge
// Assumes: AHB-Lite slave with no wait states; link inputs come on clk_link
// Notes: Link events cross by toggle; partner address word is held stable by the link side
// What this block does
// - A forward channel sequence error sets a read-only flag in bit 7 of control two.
// - Writing a one to bit 6 of control two clears the sequence error flag.
// - Bits 4-3 delay the SDA output by 250, 300, 350 or 400 ns in 50 ns steps.
// - With bit 2 set, register writes from the far side of the channel are rejected.
// - That block leaves far side accesses to local I2C targets untouched.
// - Bit 1 picks a watchdog period of about 50 us when set and about 1 s when clear.
// - Bit 0 of control two switches the bus watchdog off completely.
// - With SDA high and no bus activity for the period, the bus is taken as free.
// - With SDA low and no bus activity for the period, nine SCL pulses are driven.
// - Bits 7-1 of the partner address register hold the serializer target address.
// - A zero partner address stops all forwarding to the serializer.
// - After receive lock the partner address is loaded from the link.
// - The hold bit 0 stops that load and keeps the software value.
// - A transaction to alias zero is remapped to the far target address in bits 7-1.
//
// The AHB-Lite slave port was chosen for this implementation.
module bridge_cfg #(
  parameter int WD_SLOW_CYC = bridge_cfg_pkg::WD_SLOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic clk_link,
  input wire logic seq_err_evt,
  input wire logic partner_addr_stb,
  input wire logic [6:0] partner_addr_word,
  input wire logic rx_lock,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  input wire logic sda_drive_req,
  input wire logic tgt_req,
  input wire logic [6:0] tgt_addr,
  output logic fwd_valid,
  output logic [6:0] fwd_addr,
  output logic fwd_drop,
  input wire logic rw_req,
  input wire logic rw_local,
  input wire logic [7:0] rw_idx,
  input wire logic [7:0] rw_data,
  output logic rw_done,
  output logic rw_reject,
  output logic rw_pass
);
  typedef enum logic [2:0] {
    WD_WATCH = 3'b001,
    WD_FREE = 3'b010,
    WD_RECOV = 3'b100
  } wd_e;

  typedef struct packed {
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic dph_wr;
    logic [7:0] dph_idx;
    logic seq_err;
    logic seq_clr;
    logic [1:0] dly;
    logic wr_block;
    logic fast;
    logic wd_off;
    logic [6:0] partner;
    logic hold;
    logic [6:0] far0;
    logic [6:0] alias0;
    logic [2:0] seq_sync;
    logic [2:0] addr_sync;
    logic [1:0] lock_sync;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    wd_e wd;
    logic [bridge_cfg_pkg::WD_CNT_W-1:0] wd_cnt;
    logic [7:0] half_cnt;
    logic [3:0] pulses;
    logic [3:0] chk_rises;
    logic scl_o;
    logic scl_oe;
    logic [bridge_cfg_pkg::SDA_SR_W-1:0] sda_sr;
    logic sda_o;
    logic sda_oe;
    logic fwd_valid;
    logic [6:0] fwd_addr;
    logic fwd_drop;
    logic rw_done;
    logic rw_reject;
    logic rw_pass;
  } sys_s;

  typedef struct packed {
    logic seq_tog;
    logic addr_tog;
    logic [6:0] addr_word;
  } link_s;

  sys_s s;
  sys_s n;
  link_s l;
  link_s nl;
  logic ahb_sel;
  logic rw_ok;
  logic seq_evt;
  logic addr_evt;
  logic act;
  logic clr_hit;
  logic [bridge_cfg_pkg::WD_CNT_W-1:0] wd_lim;

  // Byte address to register index, anything outside the window is unmapped
  function automatic logic [7:0] addr_idx(input logic [31:0] a);
    addr_idx = (a[31:bridge_cfg_pkg::IDX_MSB+1] == '0 && a[1:0] == 2'b00) ?
      a[bridge_cfg_pkg::IDX_MSB:bridge_cfg_pkg::IDX_LSB] : bridge_cfg_pkg::IDX_NONE;
  endfunction : addr_idx

  // Register read mux; unmapped and reserved bits read zero
  function automatic logic [31:0] reg_rd(input sys_s st, input logic [7:0] idx);
    reg_rd = '0;
    case (idx)
      bridge_cfg_pkg::IDX_CTL2: begin
        reg_rd[bridge_cfg_pkg::B_SEQ_ERR] = st.seq_err;
        reg_rd[bridge_cfg_pkg::B_SEQ_CLR] = st.seq_clr;
        reg_rd[bridge_cfg_pkg::B_DLY_HI:bridge_cfg_pkg::B_DLY_LO] = st.dly;
        reg_rd[bridge_cfg_pkg::B_WR_BLOCK] = st.wr_block;
        reg_rd[bridge_cfg_pkg::B_FAST] = st.fast;
        reg_rd[bridge_cfg_pkg::B_WD_OFF] = st.wd_off;
      end
      bridge_cfg_pkg::IDX_PARTNER: begin
        reg_rd[bridge_cfg_pkg::B_ADDR_HI:bridge_cfg_pkg::B_ADDR_LO] = st.partner;
        reg_rd[bridge_cfg_pkg::B_HOLD] = st.hold;
      end
      bridge_cfg_pkg::IDX_FAR0: reg_rd[bridge_cfg_pkg::B_ADDR_HI:bridge_cfg_pkg::B_ADDR_LO] = st.far0;
      bridge_cfg_pkg::IDX_ALIAS0: reg_rd[bridge_cfg_pkg::B_ADDR_HI:bridge_cfg_pkg::B_ADDR_LO] = st.alias0;
      bridge_cfg_pkg::IDX_STAT: begin
        reg_rd[bridge_cfg_pkg::B_ST_FREE] = (st.wd == WD_FREE);
        reg_rd[bridge_cfg_pkg::B_ST_RECOV] = (st.wd == WD_RECOV);
        reg_rd[bridge_cfg_pkg::B_ST_LOCK] = st.lock_sync[1];
      end
      default: reg_rd = '0;
    endcase
  endfunction : reg_rd

  // Register write; the error flag itself is not writable, bit 6 clears it
  function automatic sys_s reg_wr(input sys_s st, input logic [7:0] idx, input logic [7:0] d);
    reg_wr = st;
    case (idx)
      bridge_cfg_pkg::IDX_CTL2: begin
        reg_wr.seq_clr = d[bridge_cfg_pkg::B_SEQ_CLR];
        if (d[bridge_cfg_pkg::B_SEQ_CLR]) begin
          reg_wr.seq_err = 1'b0;
        end
        reg_wr.dly = d[bridge_cfg_pkg::B_DLY_HI:bridge_cfg_pkg::B_DLY_LO];
        reg_wr.wr_block = d[bridge_cfg_pkg::B_WR_BLOCK];
        reg_wr.fast = d[bridge_cfg_pkg::B_FAST];
        reg_wr.wd_off = d[bridge_cfg_pkg::B_WD_OFF];
      end
      bridge_cfg_pkg::IDX_PARTNER: begin
        reg_wr.partner = d[bridge_cfg_pkg::B_ADDR_HI:bridge_cfg_pkg::B_ADDR_LO];
        reg_wr.hold = d[bridge_cfg_pkg::B_HOLD];
      end
      bridge_cfg_pkg::IDX_FAR0: reg_wr.far0 = d[bridge_cfg_pkg::B_ADDR_HI:bridge_cfg_pkg::B_ADDR_LO];
      bridge_cfg_pkg::IDX_ALIAS0: reg_wr.alias0 = d[bridge_cfg_pkg::B_ADDR_HI:bridge_cfg_pkg::B_ADDR_LO];
      default: reg_wr = st;
    endcase
  endfunction : reg_wr

  // Link side: events become toggles, the address word is captured with its toggle
  always_comb begin
    nl = l;
    if (seq_err_evt) begin
      nl.seq_tog = ~l.seq_tog;
    end
    if (partner_addr_stb) begin
      nl.addr_tog = ~l.addr_tog;
      nl.addr_word = partner_addr_word;
    end
  end

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      l <= '0;
    end else begin
      l <= nl;
    end
  end

  // Edge detectors read only the second and third synchroniser stages
  assign seq_evt = s.seq_sync[1] ^ s.seq_sync[2];
  assign addr_evt = s.addr_sync[1] ^ s.addr_sync[2];
  assign act = (s.scl_sync[1] ^ s.scl_sync[2]) | (s.sda_sync[1] ^ s.sda_sync[2]);
  assign ahb_sel = hsel && htrans[bridge_cfg_pkg::HTRANS_ACT] && hready;
  assign rw_ok = rw_req && rw_local && !s.wr_block;
  assign clr_hit = (rw_ok && rw_idx == bridge_cfg_pkg::IDX_CTL2 && rw_data[bridge_cfg_pkg::B_SEQ_CLR]) ||
    (s.dph_wr && s.dph_idx == bridge_cfg_pkg::IDX_CTL2 && hwdata[bridge_cfg_pkg::B_SEQ_CLR]);
  assign wd_lim = s.fast ? bridge_cfg_pkg::WD_CNT_W'(bridge_cfg_pkg::WD_FAST_CYC - 1) :
    bridge_cfg_pkg::WD_CNT_W'(WD_SLOW_CYC - 1);

  // System side next state
  always_comb begin
    int tap;
    tap = 0;
    n = s;
    n.seq_sync = {s.seq_sync[1:0], l.seq_tog};
    n.addr_sync = {s.addr_sync[1:0], l.addr_tog};
    n.lock_sync = {s.lock_sync[0], rx_lock};
    n.scl_sync = {s.scl_sync[1:0], scl_i};
    n.sda_sync = {s.sda_sync[1:0], sda_i};
    // Zero wait state slave, always OKAY
    n.hready = 1'b1;
    n.hresp = 1'b0;
    n.dph_wr = ahb_sel && hwrite;
    n.dph_idx = addr_idx(haddr);
    // Far side register writes; far side target traffic passes regardless
    n.rw_done = rw_ok;
    n.rw_reject = rw_req && rw_local && s.wr_block;
    n.rw_pass = rw_req && !rw_local;
    // Auto load first so any software write in the same cycle wins
    if (addr_evt && s.lock_sync[1] && !s.hold) begin
      n.partner = l.addr_word;
    end
    if (rw_ok) begin
      n = reg_wr(n, rw_idx, rw_data);
    end
    if (s.dph_wr) begin
      n = reg_wr(n, s.dph_idx, hwdata[7:0]);
    end
    // Set beats clear so no error is lost
    if (seq_evt) begin
      n.seq_err = 1'b1;
    end
    // Read data from next state so a write just before is seen
    n.hrdata = (ahb_sel && !hwrite) ? reg_rd(n, addr_idx(haddr)) : '0;
    // Forwarding decision toward the serializer
    n.fwd_valid = 1'b0;
    n.fwd_drop = 1'b0;
    if (tgt_req) begin
      if (s.partner == bridge_cfg_pkg::ADDR_NONE) begin
        n.fwd_drop = 1'b1;
      end else if (s.alias0 != bridge_cfg_pkg::ADDR_NONE && tgt_addr == s.alias0) begin
        n.fwd_valid = 1'b1;
        n.fwd_addr = s.far0;
      end else if (tgt_addr == s.partner) begin
        n.fwd_valid = 1'b1;
        n.fwd_addr = tgt_addr;
      end else begin
        n.fwd_drop = 1'b1;
      end
    end
    // SDA output delay line, tap picked by the delay code
    tap = bridge_cfg_pkg::SDA_TAP0 + int'(s.dly) * bridge_cfg_pkg::SDA_STEP_CYC;
    n.sda_sr = {s.sda_sr[bridge_cfg_pkg::SDA_SR_W-2:0], sda_drive_req};
    n.sda_oe = s.sda_sr[tap];
    // Bus watchdog; own recovery edges are not counted as activity, except the final SCL release after WD_RECOV
    case (s.wd)
      WD_WATCH: begin
        if (act) begin
          n.wd_cnt = '0;
        end else if (s.wd_cnt == wd_lim) begin
          n.wd_cnt = '0;
          if (s.sda_sync[1]) begin
            n.wd = WD_FREE;
          end else begin
            n.wd = WD_RECOV;
            n.half_cnt = '0;
            n.pulses = '0;
            n.scl_oe = 1'b1;
            n.chk_rises = 4'h1;
          end
        end else begin
          n.wd_cnt = s.wd_cnt + 1'b1;
        end
      end
      WD_FREE: begin
        if (act) begin
          n.wd = WD_WATCH;
        end
      end
      WD_RECOV: begin
        if (s.half_cnt == 8'(bridge_cfg_pkg::RECOV_HALF_CYC - 1)) begin
          n.half_cnt = '0;
          n.scl_oe = ~s.scl_oe;
          if (s.scl_oe) begin
            n.pulses = s.pulses + 1'b1;
            if (s.pulses == 4'(bridge_cfg_pkg::RECOV_PULSES - 1)) begin
              n.wd = WD_WATCH;
            end
          end else begin
            n.chk_rises = s.chk_rises + 1'b1;
          end
        end else begin
          n.half_cnt = s.half_cnt + 1'b1;
        end
      end
      default: n.wd = WD_WATCH;
    endcase
    // Watchdog off parks it and releases SCL at once
    if (s.wd_off) begin
      n.wd = WD_WATCH;
      n.wd_cnt = '0;
      n.scl_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.wd <= WD_WATCH;
      s.scl_sync <= '1; // Pins idle high, so no false edge after reset
      s.sda_sync <= '1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flops; pins only ever pull low
  assign hreadyout = s.hready;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign scl_o = s.scl_o;
  assign scl_oe = s.scl_oe;
  assign sda_o = s.sda_o;
  assign sda_oe = s.sda_oe;
  assign fwd_valid = s.fwd_valid;
  assign fwd_addr = s.fwd_addr;
  assign fwd_drop = s.fwd_drop;
  assign rw_done = s.rw_done;
  assign rw_reject = s.rw_reject;
  assign rw_pass = s.rw_pass;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  sequence sq_rise_code0;
    $rose(sda_drive_req) && s.dly == 2'b00;
  endsequence
  sequence sq_rise_code3;
    $rose(sda_drive_req) && s.dly == 2'b11;
  endsequence

  a_seq_err_set: assert property (seq_evt |=> s.seq_err)
    else $error("sequence error event not flagged");
  a_seq_err_clear: assert property (clr_hit && !seq_evt |=> !s.seq_err)
    else $error("sequence error not cleared");
  a_seq_err_sticky: assert property (s.seq_err && !clr_hit |=> s.seq_err)
    else $error("sequence error dropped without clear");
  a_sda_dly_min: assert property (sq_rise_code0 ##1 s.dly == 2'b00 [*8] ##1 s.dly == 2'b00 |-> !sda_oe ##1 sda_oe)
    else $error("sda delay wrong for code zero");
  a_sda_dly_max: assert property (sq_rise_code3 ##1 s.dly == 2'b11 [*8] |-> !sda_oe ##7 !sda_oe ##1 sda_oe)
    else $error("sda delay wrong for code three");
  a_block_reject: assert property (rw_req && rw_local && s.wr_block |=> rw_reject && !rw_done)
    else $error("blocked far write not rejected");
  a_far_pass: assert property (rw_req && !rw_local |=> rw_pass && !rw_reject)
    else $error("far target access affected");
  a_wd_period: assert property (s.wd == WD_WATCH && n.wd != WD_WATCH |-> s.wd_cnt == wd_lim && !s.wd_off)
    else $error("watchdog expired at wrong count");
  a_wd_disable: assert property (s.wd_off |=> s.wd == WD_WATCH && !scl_oe && s.wd_cnt == '0)
    else $error("watchdog active while disabled");
  a_bus_free: assert property (s.wd == WD_WATCH && s.wd_cnt == wd_lim && !act && !s.wd_off && s.sda_sync[1]
    |=> s.wd == WD_FREE)
    else $error("idle high bus not taken as free");
  a_recov_nine: assert property (s.wd == WD_RECOV && n.wd == WD_WATCH && !s.wd_off
    |-> s.chk_rises == 4'h9)
    else $error("recovery pulse count not nine");
  a_zero_partner: assert property (tgt_req && s.partner == bridge_cfg_pkg::ADDR_NONE |=> fwd_drop && !fwd_valid)
    else $error("forwarded with zero partner");
  a_alias_remap: assert property (tgt_req && s.partner != bridge_cfg_pkg::ADDR_NONE &&
    s.alias0 != bridge_cfg_pkg::ADDR_NONE && tgt_addr == s.alias0 |=> fwd_valid && fwd_addr == $past(s.far0))
    else $error("alias zero not remapped");
  a_auto_load: assert property (addr_evt && s.lock_sync[1] && !s.hold && !rw_ok && !s.dph_wr
    |=> s.partner == $past(l.addr_word))
    else $error("partner address not loaded");
  a_hold_keep: assert property (addr_evt && s.hold && !rw_ok && !s.dph_wr |=> $stable(s.partner))
    else $error("held partner address overwritten");
endmodule : bridge_cfg

//--- dv/far_side_model.sv
// Purpose: Far side of the bridge: serializer link events and the open-drain I2C lines
// Assumes: Pull-ups on SCL and SDA; strobes spaced well apart by the caller
// Notes: Address word is scrambled once its strobe has passed
module far_side_model (
  input wire logic clk_link,
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic seq_err_evt,
  output logic partner_addr_stb,
  output logic [6:0] partner_addr_word,
  output logic scl_i,
  output logic sda_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_hold_low;
  // Idle link, bus released
  initial begin
    seq_err_evt = 1'b0;
    partner_addr_stb = 1'b0;
    partner_addr_word = 7'h55;
    sda_hold_low = 1'b0;
  end
  // Wired-AND with pull-ups, a stuck target may hold SDA low
  assign scl_i = ~scl_oe;
  assign sda_i = ~(sda_oe | sda_hold_low);
  // One-cycle sequence error on the link clock
  task send_err();
    @(posedge clk_link);
    seq_err_evt <= 1'b1;
    @(posedge clk_link);
    seq_err_evt <= 1'b0;
  endtask : send_err
  // Address word valid only with its strobe, so stale values cannot pass
  task send_addr(input logic [6:0] a);
    @(posedge clk_link);
    partner_addr_word <= a;
    partner_addr_stb <= 1'b1;
    @(posedge clk_link);
    partner_addr_stb <= 1'b0;
    partner_addr_word <= ~a;
  endtask : send_addr
endmodule : far_side_model

//--- dv/control_channel_i2c_bridge_config_tb.sv
// Purpose: Self-checking bench for the bridge configuration block
// Assumes: Zero-wait AHB slave, short slow watchdog of 3000 cycles
// Notes: Reset held long enough for two link clock edges
module control_channel_i2c_bridge_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW = 3000;
  localparam logic [31:0] A_CTL2 = {22'h0, bridge_cfg_pkg::IDX_CTL2, 2'b00};
  localparam logic [31:0] A_PART = {22'h0, bridge_cfg_pkg::IDX_PARTNER, 2'b00};
  localparam logic [31:0] A_FAR0 = {22'h0, bridge_cfg_pkg::IDX_FAR0, 2'b00};
  localparam logic [31:0] A_ALIAS = {22'h0, bridge_cfg_pkg::IDX_ALIAS0, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, bridge_cfg_pkg::IDX_STAT, 2'b00};
  logic clk_sys = 1'b0, clk_link = 1'b0, rstn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic seq_err_evt, partner_addr_stb, rx_lock = 1'b0, scl_i, sda_i, scl_o, scl_oe, sda_o, sda_oe;
  logic [6:0] partner_addr_word, tgt_addr = '0, fwd_addr;
  logic sda_drive_req = 1'b0, tgt_req = 1'b0, fwd_valid, fwd_drop;
  logic rw_req = 1'b0, rw_local = 1'b0, rw_done, rw_reject, rw_pass;
  logic [7:0] rw_idx = '0, rw_data = '0;
  logic scl_oe_q = 1'b0;
  int num_errors = 0, cmp_count = 0, pulses = 0;
  always #12.5 clk_sys = ~clk_sys;
  always #80 clk_link = ~clk_link;
  assign hready = hreadyout;
  bridge_cfg #(.WD_SLOW_CYC(SLOW)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .clk_link(clk_link), .seq_err_evt(seq_err_evt),
    .partner_addr_stb(partner_addr_stb), .partner_addr_word(partner_addr_word), .rx_lock(rx_lock),
    .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .sda_drive_req(sda_drive_req), .tgt_req(tgt_req), .tgt_addr(tgt_addr), .fwd_valid(fwd_valid),
    .fwd_addr(fwd_addr), .fwd_drop(fwd_drop), .rw_req(rw_req), .rw_local(rw_local), .rw_idx(rw_idx),
    .rw_data(rw_data), .rw_done(rw_done), .rw_reject(rw_reject), .rw_pass(rw_pass));
  far_side_model partner_u (.clk_link(clk_link), .scl_oe(scl_oe), .sda_oe(sda_oe), .seq_err_evt(seq_err_evt),
    .partner_addr_stb(partner_addr_stb), .partner_addr_word(partner_addr_word), .scl_i(scl_i), .sda_i(sda_i));
  // Count recovery clocks on SCL
  always @(posedge clk_sys) begin
    scl_oe_q <= scl_oe;
    if (scl_oe === 1'b1 && scl_oe_q === 1'b0) pulses <= pulses + 1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : wait_cyc
  // Single AHB transfer, waits on hready in both phases
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    check(r, exp);
  endtask : rd_chk
  // Far side register write or target access, answer one cycle later
  task automatic far_rw(input logic loc, input logic [7:0] idx, input logic [7:0] d, input logic [2:0] exp);
    @(posedge clk_sys);
    rw_req <= 1'b1;
    rw_local <= loc;
    rw_idx <= idx;
    rw_data <= d;
    @(posedge clk_sys);
    rw_req <= 1'b0;
    @(posedge clk_sys);
    check({29'h0, rw_done, rw_reject, rw_pass}, {29'h0, exp});
  endtask : far_rw
  task automatic fwd(input logic [6:0] a, input logic v, input logic [6:0] exp_a);
    @(posedge clk_sys);
    tgt_req <= 1'b1;
    tgt_addr <= a;
    @(posedge clk_sys);
    tgt_req <= 1'b0;
    @(posedge clk_sys);
    check({30'h0, fwd_valid, fwd_drop}, {30'h0, v, ~v});
    if (v) check({25'h0, fwd_addr}, {25'h0, exp_a});
  endtask : fwd
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    #1500000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    // Long enough for both domains to see two edges
    repeat (14) @(posedge clk_sys);
    rstn <= 1'b1;
    wait_cyc(2);
    rd_chk(A_CTL2, 32'h0);
    rd_chk(A_PART, 32'h0);
    rd_chk(A_FAR0, 32'h0);
    rd_chk(A_ALIAS, 32'h0);
    rd_chk(32'h3FC, 32'h0);
    check({29'h0, hresp, scl_o, sda_o}, 32'h0);
    $display("reset values done");
    partner_u.send_err();
    wait_cyc(8);
    rd_chk(A_CTL2, 32'h80);
    wr(A_CTL2, 32'h80);
    rd_chk(A_CTL2, 32'h80);
    wr(A_CTL2, 32'h40);
    rd_chk(A_CTL2, 32'h40);
    $display("sequence error done");
    wr(A_CTL2, 32'h04);
    far_rw(1'b1, bridge_cfg_pkg::IDX_FAR0, 8'h22, 3'b010);
    far_rw(1'b0, 8'h00, 8'h00, 3'b001);
    rd_chk(A_FAR0, 32'h0);
    wr(A_CTL2, 32'h00);
    far_rw(1'b1, bridge_cfg_pkg::IDX_FAR0, 8'h22, 3'b100);
    rd_chk(A_FAR0, 32'h22);
    $display("far writes done");
    partner_u.send_addr(7'h35);
    wait_cyc(8);
    rd_chk(A_PART, 32'h0);
    @(posedge clk_sys) rx_lock <= 1'b1;
    wait_cyc(6);
    partner_u.send_addr(7'h35);
    wait_cyc(8);
    rd_chk(A_PART, 32'h6A);
    wr(A_PART, 32'h51);
    partner_u.send_addr(7'h11);
    wait_cyc(8);
    rd_chk(A_PART, 32'h51);
    $display("partner address done");
    fwd(7'h28, 1'b1, 7'h28);
    wr(A_ALIAS, 32'h60);
    fwd(7'h30, 1'b1, 7'h11);
    fwd(7'h12, 1'b0, 7'h00);
    wr(A_PART, 32'h00);
    fwd(7'h28, 1'b0, 7'h00);
    $display("forwarding done");
    for (int c = 0; c < 4; c++) begin
      int n;
      wr(A_CTL2, 32'(c) << 3);
      @(posedge clk_sys) sda_drive_req <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (sda_oe !== 1'b1 && n < 40);
      check(32'(n), 32'(11 + 2 * c));
      sda_drive_req <= 1'b0;
      wait_cyc(20);
    end
    $display("sda delay done");
    wr(A_CTL2, 32'h02);
    @(posedge clk_sys) partner_u.sda_hold_low <= 1'b1;
    wait_cyc(1900);
    check(32'(pulses), 32'h0);
    wait_cyc(300);
    rd_chk(A_STAT, 32'h6);
    wait_cyc(4300);
    check(32'(pulses), 32'h9);
    partner_u.sda_hold_low <= 1'b0;
    wait_cyc(1900);
    rd_chk(A_STAT, 32'h4);
    wait_cyc(300);
    rd_chk(A_STAT, 32'h5);
    wr(A_CTL2, 32'h03);
    @(posedge clk_sys) partner_u.sda_hold_low <= 1'b1;
    wait_cyc(2500);
    check(32'(pulses), 32'h9);
    partner_u.sda_hold_low <= 1'b0;
    wr(A_CTL2, 32'h00);
    wait_cyc(2500);
    rd_chk(A_STAT, 32'h4);
    wait_cyc(700);
    rd_chk(A_STAT, 32'h5);
    $display("watchdog done");
    report_and_stop();
  end
endmodule : control_channel_i2c_bridge_config_tb
